// ---- common/dqt_regs.svh ----
// Timing counts, field positions and latency table of the data termination control.
`ifndef DQT_REGS_SVH
`define DQT_REGS_SVH

// Clock of the block in MHz and the command/address termination update time in ns.
`define DQT_CLK_MHZ        50
`define DQT_CA_UPDATE_NS   20
`define DQT_MRW_NCK        4

// Fields of the termination configuration option byte.
`define DQT_OP_RES_MSB     2
`define DQT_OP_RES_LSB     0
`define DQT_OP_EN_BIT      3
`define DQT_OP_CA_MSB      6
`define DQT_OP_CA_LSB      4

// Extra turn-off latency for a burst length of 32.
`define DQT_BL32_EXTRA     6'h08

// Turn-on and turn-off latencies in link clocks per frequency bin, sets A and B.
`define DQT_ON_A_B3        6'h04
`define DQT_ON_A_B4        6'h04
`define DQT_ON_A_B5        6'h06
`define DQT_ON_A_B6        6'h06
`define DQT_ON_A_B7        6'h08
`define DQT_ON_B_B2        6'h06
`define DQT_ON_B_B3        6'h0c
`define DQT_ON_B_B4        6'h0e
`define DQT_ON_B_B5        6'h12
`define DQT_ON_B_B6        6'h14
`define DQT_ON_B_B7        6'h18
`define DQT_OFF_A_B3       6'h14
`define DQT_OFF_A_B4       6'h16
`define DQT_OFF_A_B5       6'h18
`define DQT_OFF_A_B6       6'h1a
`define DQT_OFF_A_B7       6'h1c
`define DQT_OFF_B_B2       6'h16
`define DQT_OFF_B_B3       6'h1c
`define DQT_OFF_B_B4       6'h20
`define DQT_OFF_B_B5       6'h24
`define DQT_OFF_B_B6       6'h28
`define DQT_OFF_B_B7       6'h2c

`endif

// ---- common/dqt_pkg.sv ----
// Types shared by the data termination control modules.
package dqt_pkg;

    // Write window sequencer: idle, or counting link clocks from the second column command.
    typedef enum logic [0:0] {
        DQT_IDLE,
        DQT_COUNT
    } dqt_win_t;

    // Whole state of the termination controller.
    typedef struct packed {
        dqt_win_t    win;
        logic        pending;
        logic [5:0]  cnt;
        logic [5:0]  on_lat;
        logic [5:0]  off_lat;
        logic        dq_on;
        logic [2:0]  ca_res;
        logic [2:0]  ca_new;
        logic [2:0]  mrw_cnt;
        logic        mrw_busy;
        logic [7:0]  ca_wait;
        logic        ca_pend;
    } dqt_state_t;

endpackage : dqt_pkg

// ---- common/dqt_sync_if.sv ----
// Carrier between the termination controller and its input synchroniser.
`timescale 1ns/10ps
interface dqt_sync_if #(
    parameter int W = 8
);
    logic [W-1:0] raw;
    logic [W-1:0] level;
    logic [W-1:0] rise;

    modport ctrl (output raw, input level, input rise);
    modport sync (input raw, output level, output rise);
endinterface : dqt_sync_if

// ---- logic/dqt_sync.sv ----
// Three-stage synchroniser with agreement filter and rising edge pulse per bit.
`timescale 1ns/10ps
module dqt_sync
    import dqt_pkg::*;
#(
    parameter int W = 8
)(
    input  wire logic clk,
    input  wire logic rst_n,
    dqt_sync_if.sync  sif
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] level;
        logic [W-1:0] rise;
    } dqt_sync_state_t;

    dqt_sync_state_t st_reg;
    dqt_sync_state_t st_next;

    // Stage one feeds stage two only; the filtered level moves once stages two and three agree.
    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = sif.raw;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < W; i++)
        begin
            st_next.rise[i] = 1'b0;
            if (st_reg.s2[i] == st_reg.s3[i])
            begin
                st_next.level[i] = st_reg.s3[i];
                st_next.rise[i]  = st_reg.s3[i] & ~st_reg.level[i];
            end
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign sif.level = st_reg.level;
    assign sif.rise  = st_reg.rise;

endmodule : dqt_sync

// ---- logic/dqt_ctrl.sv ----
// Data-path and command/address on-die termination control of the memory device.
`timescale 1ns/10ps
`include "dqt_regs.svh"
module dqt_ctrl
    import dqt_pkg::*;
#(
    parameter int CLK_MHZ      = `DQT_CLK_MHZ,
    parameter int CA_UPDATE_NS = `DQT_CA_UPDATE_NS
)(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       link_ck,
    input  wire logic       cmd_write_first,
    input  wire logic       cmd_masked_write_first,
    input  wire logic       cmd_second_column,
    input  wire logic       cmd_term_config_write,
    input  wire logic       power_down,
    input  wire logic       self_refresh,
    input  wire logic       write_leveling,
    input  wire logic [7:0] termination_config,
    input  wire logic [2:0] freq_bin,
    input  wire logic       write_latency_set_b,
    input  wire logic       burst_length_32,
    output logic            dq_term_on,
    output logic            dqs_term_on,
    output logic [2:0]      termination_resistance,
    output logic            term_mode_enabled,
    output logic            term_unavailable,
    output logic [2:0]      ca_termination_resistance,
    output logic            ca_update_pending
);
    // Update time in clk cycles, rounded up and never less than one cycle.
    localparam int CA_WAIT_RAW = (CA_UPDATE_NS * CLK_MHZ + 999) / 1000;
    localparam int CA_WAIT     = (CA_WAIT_RAW < 1) ? 1 : CA_WAIT_RAW;
    localparam logic [7:0] CA_WAIT_CYC = 8'(CA_WAIT);
    localparam logic [2:0] MRW_LAST    = 3'(`DQT_MRW_NCK - 1);

    // Bit positions inside the synchronised input bundle.
    localparam int B_CK  = 0;
    localparam int B_WR  = 1;
    localparam int B_MWR = 2;
    localparam int B_CAS = 3;
    localparam int B_MRW = 4;
    localparam int B_PD  = 5;
    localparam int B_SR  = 6;
    localparam int B_WLV = 7;

    dqt_sync_if #(.W(8)) sif ();

    dqt_state_t st_reg;
    dqt_state_t st_next;

    logic       ck_rise;
    logic       wr_seen;
    logic       cas_seen;
    logic       mrw_seen;
    logic       in_pd_sr;
    logic       in_wlev;
    logic       mode_en;
    logic       lat_valid;
    logic [5:0] lat_on;
    logic [5:0] lat_off;

    // Command, link clock, low-power and leveling pins are foreign to clk and go through the synchroniser.
    assign sif.raw = {write_leveling, self_refresh, power_down, cmd_term_config_write,
                      cmd_second_column, cmd_masked_write_first, cmd_write_first, link_ck};

    dqt_sync #(
        .W (8)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .sif   (sif.sync)
    );

    // Latency lookup by frequency bin and latency set; bins 0 and 1 and set A in bin 2 have none.
    function automatic logic [12:0] dqt_lat_lookup(
        input logic [2:0] bin,
        input logic       set_b
    );
        logic [12:0] r;
        r = '0;
        if (set_b)
        begin
            case (bin)
                3'h2: r = {1'b1, `DQT_ON_B_B2, `DQT_OFF_B_B2};
                3'h3: r = {1'b1, `DQT_ON_B_B3, `DQT_OFF_B_B3};
                3'h4: r = {1'b1, `DQT_ON_B_B4, `DQT_OFF_B_B4};
                3'h5: r = {1'b1, `DQT_ON_B_B5, `DQT_OFF_B_B5};
                3'h6: r = {1'b1, `DQT_ON_B_B6, `DQT_OFF_B_B6};
                3'h7: r = {1'b1, `DQT_ON_B_B7, `DQT_OFF_B_B7};
                default: r = '0;
            endcase
        end
        else
        begin
            case (bin)
                3'h3: r = {1'b1, `DQT_ON_A_B3, `DQT_OFF_A_B3};
                3'h4: r = {1'b1, `DQT_ON_A_B4, `DQT_OFF_A_B4};
                3'h5: r = {1'b1, `DQT_ON_A_B5, `DQT_OFF_A_B5};
                3'h6: r = {1'b1, `DQT_ON_A_B6, `DQT_OFF_A_B6};
                3'h7: r = {1'b1, `DQT_ON_A_B7, `DQT_OFF_A_B7};
                default: r = '0;
            endcase
        end
        return r;
    endfunction : dqt_lat_lookup

    // Commands count only when captured on a link clock rising edge.
    assign ck_rise  = sif.rise[B_CK];
    assign wr_seen  = ck_rise & (sif.level[B_WR] | sif.level[B_MWR]);
    assign cas_seen = ck_rise & sif.level[B_CAS];
    assign mrw_seen = ck_rise & sif.level[B_MRW];
    assign in_pd_sr = sif.level[B_PD] | sif.level[B_SR];
    assign in_wlev  = sif.level[B_WLV];

    // Mode needs a non-zero low nibble, and bit 3 clear always disables it.
    assign mode_en = (termination_config[3:0] != 4'h0)
                   & termination_config[`DQT_OP_EN_BIT];

    // Latency pair for the current bin and set, with the long burst extension on turn-off.
    always_comb
    begin
        logic [12:0] lk;
        lk        = dqt_lat_lookup(freq_bin, write_latency_set_b);
        lat_valid = lk[12];
        lat_on    = lk[11:6];
        lat_off   = lk[5:0] + (burst_length_32 ? `DQT_BL32_EXTRA : 6'h00);
    end

    // Write window sequencer and command/address update timer.
    always_comb
    begin
        st_next = st_reg;

        // A write first part arms the window; the following second column command starts it.
        if (wr_seen && mode_en && lat_valid)
            st_next.pending = 1'b1;

        case (st_reg.win)
            DQT_IDLE:
            begin
                if (cas_seen && (st_reg.pending || wr_seen))
                begin
                    st_next.win     = DQT_COUNT;
                    st_next.pending = wr_seen & mode_en & lat_valid;
                    st_next.cnt     = 6'h00;
                    st_next.on_lat  = lat_on;
                    st_next.off_lat = lat_off;
                end
            end
            DQT_COUNT:
            begin
                if (cas_seen && st_reg.pending)
                begin
                    // A back-to-back write restarts the count; termination already on stays on.
                    st_next.pending = wr_seen & mode_en & lat_valid;
                    st_next.cnt     = 6'h00;
                    st_next.on_lat  = lat_on;
                    st_next.off_lat = lat_off;
                end
                else if (ck_rise)
                begin
                    st_next.cnt = st_reg.cnt + 6'h01;
                    if (st_reg.cnt + 6'h01 == st_reg.on_lat)
                        st_next.dq_on = 1'b1;
                    if (st_reg.cnt + 6'h01 == st_reg.off_lat)
                    begin
                        st_next.dq_on = 1'b0;
                        st_next.win   = DQT_IDLE;
                    end
                end
            end
            default:
                st_next.win = DQT_IDLE;
        endcase

        // Leaving the mode or entering a low-power state abandons any window in flight.
        if (!mode_en || in_pd_sr)
        begin
            st_next.win     = DQT_IDLE;
            st_next.pending = 1'b0;
            st_next.dq_on   = 1'b0;
        end

        // The configuration write occupies four link clocks before the update timer runs.
        if (mrw_seen && !st_reg.mrw_busy)
        begin
            st_next.mrw_busy = 1'b1;
            st_next.mrw_cnt  = 3'h0;
            st_next.ca_new   = termination_config[`DQT_OP_CA_MSB:`DQT_OP_CA_LSB];
            st_next.ca_pend  = 1'b1;
        end
        else if (st_reg.mrw_busy && ck_rise)
        begin
            st_next.mrw_cnt = st_reg.mrw_cnt + 3'h1;
            if (st_reg.mrw_cnt + 3'h1 == MRW_LAST)
            begin
                st_next.mrw_busy = 1'b0;
                st_next.ca_wait  = CA_WAIT_CYC;
            end
        end

        // The old value stays applied until the whole update time has run out.
        if (st_reg.ca_pend && !st_reg.mrw_busy && st_reg.ca_wait != 8'h00)
        begin
            st_next.ca_wait = st_reg.ca_wait - 8'h01;
            if (st_reg.ca_wait == 8'h01)
            begin
                st_next.ca_res  = st_reg.ca_new;
                st_next.ca_pend = 1'b0;
            end
        end
    end

    // State register; everything clears to the high impedance, idle state.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    // Pin-level termination decisions; leveling overrides the write window on data lines.
    always_comb
    begin
        dq_term_on  = st_reg.dq_on & ~in_wlev & ~in_pd_sr & mode_en;
        dqs_term_on = (in_wlev & mode_en & ~in_pd_sr)
                    | (st_reg.dq_on & ~in_pd_sr & mode_en);
    end

    // The resistance code is shown even when off so the pad can preset its legs.
    assign termination_resistance = termination_config[`DQT_OP_RES_MSB:`DQT_OP_RES_LSB];
    assign term_mode_enabled      = mode_en;
    assign term_unavailable       = mode_en & ~lat_valid;
    assign ca_termination_resistance = st_reg.ca_res;
    assign ca_update_pending         = st_reg.ca_pend;

endmodule : dqt_ctrl

// ---- verification/dqt_ctrl_properties.sv ----
// Port-level checks of the termination controller.
`timescale 1ns/10ps
module dqt_ctrl_properties (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       cmd_second_column,
    input wire logic       power_down,
    input wire logic       self_refresh,
    input wire logic       write_leveling,
    input wire logic [7:0] termination_config,
    input wire logic [2:0] freq_bin,
    input wire logic       write_latency_set_b,
    input wire logic       dq_term_on,
    input wire logic       dqs_term_on,
    input wire logic [2:0] termination_resistance,
    input wire logic       term_mode_enabled,
    input wire logic       term_unavailable,
    input wire logic [2:0] ca_termination_resistance,
    input wire logic       ca_update_pending
);
    logic [9:0] sc_age_reg;
    logic [9:0] sc_age_next;

    // Cycles since the second column pin was last high; starts saturated so a stray rise fails.
    always_comb
    begin
        sc_age_next = (sc_age_reg == 10'h3ff) ? sc_age_reg : sc_age_reg + 10'h001;
        if (cmd_second_column)
            sc_age_next = 10'h000;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sc_age_reg <= 10'h3ff;
        else
            sc_age_reg <= sc_age_next;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Six cycles leave room for the three-stage synchroniser on the low-power and leveling levels.
    a_mode_decode: assert property (term_mode_enabled == termination_config[3])
        else $error("mode enable does not follow option bit 3");
    a_res_field: assert property (termination_resistance == termination_config[2:0])
        else $error("resistance code does not follow option bits");
    a_unavail_bins: assert property (term_unavailable == (term_mode_enabled && ((freq_bin < 3'h2)
        || (freq_bin == 3'h2 && !write_latency_set_b)))) else $error("unavailable flag wrong");
    a_lowpower_off: assert property ((power_down || self_refresh) [*6] |-> !dq_term_on && !dqs_term_on)
        else $error("termination on in low power state");
    a_level_dq_off: assert property (write_leveling [*6] |-> !dq_term_on)
        else $error("data termination on while leveling");
    a_level_dqs_on: assert property ((write_leveling && term_mode_enabled
        && !power_down && !self_refresh) [*6] |-> dqs_term_on) else $error("strobe not terminated");
    a_level_dis_off: assert property ((write_leveling && !term_mode_enabled) [*6] |-> !dqs_term_on)
        else $error("strobe terminated with mode off");
    a_on_after_cmd: assert property ($rose(dq_term_on) |-> sc_age_reg >= 10'h014 && sc_age_reg <= 10'h0fa)
        else $error("termination rose without matching second column");
    a_ca_apply: assert property ($changed(ca_termination_resistance) |-> $fell(ca_update_pending))
        else $error("command bus value changed outside the update point");
    a_ca_span: assert property ($rose(ca_update_pending) |-> ca_update_pending [*8])
        else $error("command bus update finished too early");
endmodule : dqt_ctrl_properties

// ---- verification/dqt_mc_model.sv ----
// Memory controller model: free-running link clock and command pins.
`timescale 1ns/10ps
module dqt_mc_model (
    output logic link_ck,
    output logic cmd_write_first,
    output logic cmd_masked_write_first,
    output logic cmd_second_column,
    output logic cmd_term_config_write
);
    logic [3:0] next_cmd;

    // The link clock runs free, offset so that its edges never meet the system clock's.
    initial
    begin
        {link_ck, cmd_write_first, cmd_masked_write_first} = 3'h0;
        {cmd_second_column, cmd_term_config_write, next_cmd} = 6'h00;
        #7;
        forever #80 link_ck = ~link_ck;
    end

    // Pins move on falling edges only, so they stand steady around each sampling rise.
    always @(negedge link_ck)
    begin
        {cmd_write_first, cmd_masked_write_first, cmd_second_column, cmd_term_config_write} <= next_cmd;
        next_cmd <= 4'h0;
    end

    // Present one command for one link clock; returns at the rise that samples it.
    task issue(input logic [3:0] c);
        next_cmd = c;
        @(negedge link_ck);
        @(posedge link_ck);
    endtask : issue

    // A write always pairs its first part with the second column command that follows.
    task write(input logic masked);
        issue(masked ? 4'h4 : 4'h8);
        issue(4'h2);
    endtask : write
endmodule : dqt_mc_model

// ---- verification/dqt_ctrl_tb.sv ----
// Self-checking bench of the termination controller.
`timescale 1ns/10ps
module dqt_ctrl_tb;
    typedef struct packed {
        logic [2:0] bin;
        logic       set_b;
        logic       blen32;
        logic       masked;
        logic [5:0] on;
        logic [5:0] off;
    } dqt_row_t;

    logic clk, rst_n, link_ck, cmd_write_first, cmd_masked_write_first, cmd_second_column;
    logic cmd_term_config_write, power_down, self_refresh, write_leveling, write_latency_set_b;
    logic burst_length_32, dq_term_on, dqs_term_on, term_mode_enabled, term_unavailable;
    logic ca_update_pending;
    logic [7:0] termination_config;
    logic [2:0] freq_bin, termination_resistance, ca_termination_resistance;
    int         n_mismatch, cmp_count, k, j;

    // Window bounds in link clocks after the second column; zero marks a bin without termination.
    dqt_row_t rows [14] = '{
        '{3'h1, 1'h1, 1'h0, 1'h0, 6'h00, 6'h00}, '{3'h2, 1'h0, 1'h0, 1'h1, 6'h00, 6'h00},
        '{3'h2, 1'h1, 1'h0, 1'h0, 6'h06, 6'h16}, '{3'h3, 1'h1, 1'h0, 1'h1, 6'h0c, 6'h1c},
        '{3'h4, 1'h1, 1'h0, 1'h0, 6'h0e, 6'h20}, '{3'h5, 1'h1, 1'h0, 1'h1, 6'h12, 6'h24},
        '{3'h6, 1'h1, 1'h0, 1'h0, 6'h14, 6'h28}, '{3'h7, 1'h1, 1'h0, 1'h1, 6'h18, 6'h2c},
        '{3'h3, 1'h0, 1'h0, 1'h0, 6'h04, 6'h14}, '{3'h4, 1'h0, 1'h0, 1'h1, 6'h04, 6'h16},
        '{3'h5, 1'h0, 1'h0, 1'h0, 6'h06, 6'h18}, '{3'h6, 1'h0, 1'h0, 1'h1, 6'h06, 6'h1a},
        '{3'h7, 1'h0, 1'h1, 1'h0, 6'h08, 6'h24}, '{3'h7, 1'h0, 1'h0, 1'h1, 6'h08, 6'h1c}};

    dqt_mc_model mc_i (.link_ck, .cmd_write_first, .cmd_masked_write_first, .cmd_second_column,
        .cmd_term_config_write);
    dqt_ctrl dqt_ctrl_i (.clk, .rst_n, .link_ck, .cmd_write_first, .cmd_masked_write_first,
        .cmd_second_column, .cmd_term_config_write, .power_down, .self_refresh, .write_leveling,
        .termination_config, .freq_bin, .write_latency_set_b, .burst_length_32, .dq_term_on,
        .dqs_term_on, .termination_resistance, .term_mode_enabled, .term_unavailable,
        .ca_termination_resistance, .ca_update_pending);

    // System clock, 20 ns.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task chk(input logic act, input logic exp);
        cmp_count++;
        if (act !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t act %h exp %h", $time, act, exp);
        end
    endtask : chk

    task chk3(input logic [2:0] act, input logic [2:0] exp);
        cmp_count++;
        if (act !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t act %h exp %h", $time, act, exp);
        end
    endtask : chk3

    task results;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // Rows first, then decode, low power, leveling, command bus update and a mid-run reset.
    initial
    begin
        {rst_n, power_down, self_refresh, write_leveling, write_latency_set_b} = 5'h00;
        {burst_length_32, n_mismatch, cmp_count} = 65'h0;
        termination_config = 8'h0b;
        freq_bin = 3'h7;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        foreach (rows[i])
        begin
            @(posedge clk);
            freq_bin <= rows[i].bin;
            write_latency_set_b <= rows[i].set_b;
            burst_length_32 <= rows[i].blen32;
            @(negedge clk);
            chk(term_unavailable, rows[i].on == 6'h00);
            mc_i.write(rows[i].masked);
            for (k = 1; k < 55; k++)
            begin
                @(posedge link_ck);
                chk(dq_term_on, k > rows[i].on && k <= rows[i].off);
                chk(dqs_term_on, k > rows[i].on && k <= rows[i].off);
            end
        end
        @(posedge clk);
        termination_config <= 8'h07;
        @(negedge clk);
        chk(term_mode_enabled, 1'b0);
        chk3(termination_resistance, 3'h7);
        mc_i.write(1'b0);
        for (k = 1; k < 12; k++)
        begin
            @(posedge link_ck);
            chk(dq_term_on, 1'b0);
        end
        @(posedge clk);
        termination_config <= 8'h0e;
        @(negedge clk);
        chk(term_mode_enabled, 1'b1);
        chk3(termination_resistance, 3'h6);
        // Low power must cut a live window at once, whatever the count says.
        for (j = 0; j < 2; j++)
        begin
            mc_i.write(1'b0);
            repeat (10) @(posedge link_ck);
            chk(dq_term_on, 1'b1);
            @(posedge clk);
            {power_down, self_refresh} <= (j == 0) ? 2'h2 : 2'h1;
            repeat (8) @(negedge clk);
            chk(dq_term_on, 1'b0);
            chk(dqs_term_on, 1'b0);
            @(posedge clk);
            {power_down, self_refresh} <= 2'h0;
            repeat (40) @(posedge link_ck);
        end
        @(posedge clk);
        write_leveling <= 1'b1;
        repeat (8) @(negedge clk);
        chk(dqs_term_on, 1'b1);
        chk(dq_term_on, 1'b0);
        @(posedge clk);
        termination_config <= 8'h06;
        repeat (8) @(negedge clk);
        chk(dqs_term_on, 1'b0);
        chk(dq_term_on, 1'b0);
        @(posedge clk);
        write_leveling <= 1'b0;
        termination_config <= 8'h5e;
        mc_i.issue(4'h1);
        repeat (8) @(negedge clk);
        chk(ca_update_pending, 1'b1);
        chk3(ca_termination_resistance, 3'h0);
        for (k = 0; k < 100 && ca_update_pending !== 1'b0; k++)
            @(negedge clk);
        if (k == 100)
        begin
            n_mismatch++;
            results();
        end
        chk3(ca_termination_resistance, 3'h5);
        repeat (4) @(posedge link_ck);
        mc_i.write(1'b1);
        repeat (12) @(posedge link_ck);
        chk(dq_term_on, 1'b1);
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        chk(dq_term_on, 1'b0);
        chk(ca_update_pending, 1'b0);
        chk3(ca_termination_resistance, 3'h0);
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        // After the second release the block must be idle and must still open a window.
        repeat (2) @(negedge clk);
        chk(dq_term_on, 1'b0);
        chk(ca_update_pending, 1'b0);
        repeat (8) @(posedge clk);
        mc_i.write(1'b0);
        repeat (12) @(posedge link_ck);
        chk(dq_term_on, 1'b1);
        repeat (24) @(posedge link_ck);
        chk(dq_term_on, 1'b0);
        results();
    end
endmodule : dqt_ctrl_tb

bind dqt_ctrl dqt_ctrl_properties dqt_ctrl_properties_i (.clk, .rst_n, .cmd_second_column,
    .power_down, .self_refresh, .write_leveling, .termination_config, .freq_bin,
    .write_latency_set_b, .dq_term_on, .dqs_term_on, .termination_resistance, .term_mode_enabled,
    .term_unavailable, .ca_termination_resistance, .ca_update_pending);
